// File: tmr_pkg.sv
// Constants shared by the timer/counter block and its testbench
package tmr_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_RUN_FLAGS = 8'h88;
   localparam logic [7:0] IDX_MODE_SEL = 8'h89;
   localparam logic [7:0] IDX_CNT0_LO = 8'h8a;
   localparam logic [7:0] IDX_CNT1_LO = 8'h8b;
   localparam logic [7:0] IDX_CNT0_HI = 8'h8c;
   localparam logic [7:0] IDX_CNT1_HI = 8'h8d;
   localparam logic [7:0] IDX_THIRD_CTRL = 8'hc8;
   localparam logic [7:0] IDX_THIRD_MODE = 8'hc9;
   localparam logic [7:0] IDX_RELOAD_LO = 8'hca;
   localparam logic [7:0] IDX_RELOAD_HI = 8'hcb;
   localparam logic [7:0] IDX_THIRD_LO = 8'hcc;
   localparam logic [7:0] IDX_THIRD_HI = 8'hcd;
   // Run-and-event flag register fields
   localparam int ONE_OVF = 7;
   localparam int ONE_RUN = 6;
   localparam int ZERO_OVF = 5;
   localparam int ZERO_RUN = 4;
   localparam int EXT1_FLAG = 3;
   localparam int EXT1_TYPE = 2;
   localparam int EXT0_FLAG = 1;
   localparam int EXT0_TYPE = 0;
   // Mode select register fields
   localparam int ONE_GATING = 7;
   localparam int ONE_CSEL = 6;
   localparam int ONE_MODE = 4;
   localparam int ZERO_GATING = 3;
   localparam int ZERO_CSEL = 2;
   localparam int ZERO_MODE = 0;
   // Third timer control and mode fields
   localparam int THIRD_OVF = 7;
   localparam int THIRD_EXTF = 6;
   localparam int THIRD_RUN = 2;
   localparam int THIRD_CSEL = 1;
   localparam int CLK_OE = 1;
   localparam int UPDOWN_EN = 0;
   // Mode encodings of the two legacy timers
   localparam logic [1:0] MODE_13 = 2'b00;
   localparam logic [1:0] MODE_16 = 2'b01;
   localparam logic [1:0] MODE_RELOAD8 = 2'b10;
   localparam logic [1:0] MODE_SPLIT = 2'b11;
   // Reset values and counts
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] RST_MODE3 = 2'h0;
   localparam logic [2:0] TICK_LAST = 3'h5;   // six pclk per peripheral cycle
   localparam logic [15:0] CNT_FULL = 16'hffff;
   localparam logic [4:0] PRESCALE_FULL = 5'h1f;
endpackage

// File: pin_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pins in, synchronised levels out
   input wire logic [W-1:0] pins,
   output logic [W-1:0] sync
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_s;
   sync_s s_q;
   sync_s s_d;

   // First stage feeds only the second
   always_comb begin
      s_d = s_q;
      s_d.meta = pins;
      s_d.stable = s_q.meta;
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Pins idle high; ones avoid a false low level after reset
         s_q <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync = s_q.stable;
endmodule

// File: timer_block.sv
// Two legacy timers plus up/down reload timer behind an APB slave
// Summary of operation
// R1: Timer one overflow sets flag; vector clears
// R2: Timer zero overflow sets flag; vector clears
// R3: Run bits 6 and 4 start/stop timers
// R4: Ext pin event sets flag; edge-mode ack clears
// R5: Type bit zero low level, one falling edge
// R6: Gating needs ext pin high plus run
// R7: Select bit picks prescaled clock or pin falls
// R8: Modes 13-bit, 16-bit, 8-bit reload
// R9: Reload mode refills low byte from high
// R10: Timer one mode three halts, keeps count
// R11: Timer zero mode three splits two bytes
// R12: Third timer 16-bit, run bit, two sources
// R13: Up/down enable: direction pin picks direction
// R14: Up overflow at FFFFh loads reload pair
// R15: Down underflow at reload pair loads FFFFh
// R16: External flag toggles per wrap, no interrupt
// R17: Clock-out mode reloads, no interrupt, 50% duty
// R18: Clock-out frequency pclk over 4(65536-reload)
// R19: Clock-out drives the third count pin
// R20: Software orders clock-out setup, run last
// R21: Baud and clock-out share reload pair
// R22: Timer ticks once per six pclk
// R23: Counter samples pin per cycle, counts falls
// R24: 13-bit mode uses five-bit prescaler
// R25: Hardware flag set beats software write
// R26: Software stops timer before reconfiguring
`timescale 1ns/1ps
module timer_block
   import tmr_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Board pins
   input wire logic timer_zero_count_pin,
   input wire logic timer_one_count_pin,
   input wire logic ext_irq_zero_pin_n,
   input wire logic ext_irq_one_pin_n,
   input wire logic direction_trigger_pin,
   input wire logic third_timer_count_pin_in,
   output logic third_timer_count_pin_out,
   output logic third_timer_count_pin_oe_n,
   // Interrupt controller side: vector acknowledges in
   input wire logic timer_zero_irq_ack,
   input wire logic timer_one_irq_ack,
   input wire logic ext_irq_zero_ack,
   input wire logic ext_irq_one_ack,
   // Interrupt requests and baud pulse out
   output logic timer_zero_irq,
   output logic timer_one_irq,
   output logic ext_irq_zero_req,
   output logic ext_irq_one_req,
   output logic third_timer_irq,
   output logic third_timer_ovf_pulse
);
   import tmr_pkg::*;

   typedef struct packed {
      logic [2:0] div;
      logic tick;
      logic half;
      logic [7:0] flags;
      logic [7:0] mode;
      logic [7:0] lo0;
      logic [7:0] hi0;
      logic [7:0] lo1;
      logic [7:0] hi1;
      logic [7:0] ctrl3;
      logic [1:0] mode3;
      logic [7:0] rl_lo;
      logic [7:0] rl_hi;
      logic [7:0] lo3;
      logic [7:0] hi3;
      logic [2:0] samp;
      logic [1:0] ext_prev;
      logic clk_out;
      logic pin_oe_n;
      logic ovf_pulse;
      logic ready;
      logic slverr;
      logic [7:0] rdata;
   } state_s;

   state_s s_q;
   state_s s_d;
   logic [5:0] pin_lvl;
   logic [2:0] fall;
   logic ext0_hi;
   logic ext1_hi;
   logic dir_up;
   logic wr_any;
   logic zero_ovf;
   logic one_set;
   logic third_hit;
   logic third_up;
   logic third_updown;
   logic [15:0] third_cnt;
   logic [15:0] third_rl;

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   pin_sync #(.W(6)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pins({direction_trigger_pin, ext_irq_one_pin_n, ext_irq_zero_pin_n,
             third_timer_count_pin_in, timer_one_count_pin,
             timer_zero_count_pin}),
      .sync(pin_lvl)
   );

   // ************************************************************
   // Helper functions
   // ************************************************************
   // One count step of a legacy timer; returns {overflow, high, low}
   function automatic logic [16:0] step(input logic [1:0] m,
                                        input logic [7:0] hi,
                                        input logic [7:0] lo,
                                        input logic inc);
      logic [16:0] r;
      r = {1'b0, hi, lo};
      if (inc) begin
         case (m)
            MODE_13: begin // R24
               r[4:0] = lo[4:0] + 5'h01;
               if (lo[4:0] == PRESCALE_FULL) begin
                  r[15:8] = hi + 8'h01;
                  r[16] = (hi == 8'hff);
               end
            end
            MODE_16: begin // R8
               r[15:0] = {hi, lo} + 16'h0001;
               r[16] = ({hi, lo} == CNT_FULL);
            end
            MODE_RELOAD8: begin
               r[16] = (lo == 8'hff);
               r[7:0] = r[16] ? hi : lo + 8'h01; // R9
            end
            default: begin // R11
               r[7:0] = lo + 8'h01;
               r[16] = (lo == 8'hff);
            end
         endcase
      end
      return r;
   endfunction

   // Register index of an aligned, in-range APB address
   function automatic logic [7:0] reg_index(input logic [11:0] a);
      return a[9:2];
   endfunction

   // True when the address names a mapped register
   function automatic logic reg_mapped(input logic [11:0] a);
      logic [7:0] i;
      i = a[9:2];
      return (a[1:0] == 2'b00) && (a[11:10] == 2'b00) &&
             (((i >= IDX_RUN_FLAGS) && (i <= IDX_CNT1_HI)) ||
              ((i >= IDX_THIRD_CTRL) && (i <= IDX_THIRD_HI)));
   endfunction

   // ************************************************************
   // Next-state logic
   // ************************************************************
   // Write lands on the edge where pready is already high
   always_comb begin
      logic [16:0] r0;
      logic [16:0] r1;
      logic acc;
      logic wr;
      logic [7:0] wi;
      logic [7:0] wd;
      logic run0;
      logic run1;
      logic inc0;
      logic inc1;
      logic inc_hi0;
      logic split_ovf;
      logic inc3;
      logic split0;
      r0 = '0;
      r1 = '0;
      s_d = s_q;
      acc = psel && penable;
      wr = acc && s_q.ready && pwrite && !s_q.slverr;
      wi = reg_index(paddr);
      wd = pwdata[7:0];
      wr_any = wr;
      ext0_hi = pin_lvl[3];
      ext1_hi = pin_lvl[4];
      dir_up = pin_lvl[5];
      split0 = (s_q.mode[ZERO_MODE +: 2] == MODE_SPLIT);

      // Peripheral cycle strobe, one pclk in six
      s_d.tick = (s_q.div == TICK_LAST); // R22
      s_d.div = s_d.tick ? 3'h0 : s_q.div + 3'h1;
      s_d.half = !s_q.half;

      // Count pins sampled once per peripheral cycle
      fall = s_q.samp & ~pin_lvl[2:0] & {3{s_q.tick}}; // R23
      if (s_q.tick) begin
         s_d.samp = pin_lvl[2:0];
      end

      // Timer zero
      run0 = s_q.flags[ZERO_RUN] &&
             (!s_q.mode[ZERO_GATING] || ext0_hi); // R3 R6
      inc0 = run0 && (s_q.mode[ZERO_CSEL] ? fall[0] : s_q.tick); // R7
      r0 = step(s_q.mode[ZERO_MODE +: 2], s_q.hi0, s_q.lo0, inc0);
      zero_ovf = r0[16];
      s_d.lo0 = r0[7:0];
      s_d.hi0 = r0[15:8];
      // Split mode: high byte is a plain timer on timer one's run bit
      inc_hi0 = split0 && s_q.flags[ONE_RUN] && s_q.tick; // R11
      split_ovf = inc_hi0 && (s_q.hi0 == 8'hff);
      if (inc_hi0) begin
         s_d.hi0 = s_q.hi0 + 8'h01;
      end

      // Timer one; with timer zero split it runs free for baud use
      run1 = (s_q.flags[ONE_RUN] || split0) &&
             (!s_q.mode[ONE_GATING] || ext1_hi); // R3 R6
      inc1 = run1 && (s_q.mode[ONE_MODE +: 2] != MODE_SPLIT) && // R10
             (s_q.mode[ONE_CSEL] ? fall[1] : s_q.tick); // R7
      r1 = step(s_q.mode[ONE_MODE +: 2], s_q.hi1, s_q.lo1, inc1);
      s_d.lo1 = r1[7:0];
      s_d.hi1 = r1[15:8];
      one_set = split0 ? split_ovf : r1[16]; // R11

      // Third timer
      third_cnt = {s_q.hi3, s_q.lo3};
      third_rl = {s_q.rl_hi, s_q.rl_lo};
      third_updown = s_q.mode3[UPDOWN_EN] && !s_q.mode3[CLK_OE];
      third_up = !third_updown || dir_up; // R13
      if (s_q.mode3[CLK_OE]) begin
         // Clock-out counts at half pclk, pin input ignored
         inc3 = s_q.ctrl3[THIRD_RUN] && s_q.half; // R18
      end else begin
         inc3 = s_q.ctrl3[THIRD_RUN] &&
                (s_q.ctrl3[THIRD_CSEL] ? fall[2] : s_q.tick); // R12
      end
      third_hit = inc3 && (third_up ? (third_cnt == CNT_FULL)
                                    : (third_cnt == third_rl));
      if (inc3) begin
         if (third_up) begin
            {s_d.hi3, s_d.lo3} = third_hit ? third_rl // R14
                                           : third_cnt + 16'h0001;
         end else begin
            {s_d.hi3, s_d.lo3} = third_hit ? CNT_FULL // R15
                                           : third_cnt - 16'h0001;
         end
      end
      // Overflow pulse feeds baud logic off the same reload pair
      s_d.ovf_pulse = third_hit; // R21

      // Register writes; counts written by software win over counting
      if (wr) begin
         case (wi)
            IDX_RUN_FLAGS: s_d.flags = wd;
            IDX_MODE_SEL: s_d.mode = wd;
            IDX_CNT0_LO: s_d.lo0 = wd;
            IDX_CNT1_LO: s_d.lo1 = wd;
            IDX_CNT0_HI: s_d.hi0 = wd;
            IDX_CNT1_HI: s_d.hi1 = wd;
            IDX_THIRD_CTRL: s_d.ctrl3 = wd;
            IDX_THIRD_MODE: s_d.mode3 = wd[1:0];
            IDX_RELOAD_LO: s_d.rl_lo = wd;
            IDX_RELOAD_HI: s_d.rl_hi = wd;
            IDX_THIRD_LO: s_d.lo3 = wd;
            IDX_THIRD_HI: s_d.hi3 = wd;
            default: s_d.slverr = 1'b0;
         endcase
      end

      // Vector acknowledges clear, then hardware sets win
      if (timer_zero_irq_ack) begin
         s_d.flags[ZERO_OVF] = 1'b0; // R2
      end
      if (timer_one_irq_ack) begin
         s_d.flags[ONE_OVF] = 1'b0; // R1
      end
      if (ext_irq_zero_ack && s_q.flags[EXT0_TYPE]) begin
         s_d.flags[EXT0_FLAG] = 1'b0; // R4
      end
      if (ext_irq_one_ack && s_q.flags[EXT1_TYPE]) begin
         s_d.flags[EXT1_FLAG] = 1'b0; // R4
      end
      if (zero_ovf) begin
         s_d.flags[ZERO_OVF] = 1'b1; // R2 R25
      end
      if (one_set) begin
         s_d.flags[ONE_OVF] = 1'b1; // R1 R25
      end

      // External inputs: level mode mirrors the pin, edge mode latches
      s_d.ext_prev = {ext1_hi, ext0_hi};
      if (!s_q.flags[EXT0_TYPE]) begin
         s_d.flags[EXT0_FLAG] = !ext0_hi; // R5
      end else if (s_q.ext_prev[0] && !ext0_hi) begin
         s_d.flags[EXT0_FLAG] = 1'b1; // R4 R5 R25
      end
      if (!s_q.flags[EXT1_TYPE]) begin
         s_d.flags[EXT1_FLAG] = !ext1_hi; // R5
      end else if (s_q.ext_prev[1] && !ext1_hi) begin
         s_d.flags[EXT1_FLAG] = 1'b1; // R4 R5 R25
      end

      // Third timer wrap: flag, toggle or clock edge
      if (third_hit) begin
         if (s_q.mode3[CLK_OE]) begin
            s_d.clk_out = !s_q.clk_out; // R17 R18
         end else begin
            s_d.ovf_pulse = 1'b1;
            s_d.ctrl3[THIRD_OVF] = 1'b1; // R14 R15 R25
         end
         if (third_updown) begin
            s_d.ctrl3[THIRD_EXTF] = !s_d.ctrl3[THIRD_EXTF]; // R16
         end
      end
      s_d.pin_oe_n = !s_d.mode3[CLK_OE]; // R19

      // APB answer one cycle after the access phase opens
      s_d.ready = acc && !s_q.ready;
      s_d.slverr = acc && !s_q.ready && !reg_mapped(paddr);
      if (acc && !s_q.ready) begin
         case (wi)
            IDX_RUN_FLAGS: s_d.rdata = s_q.flags;
            IDX_MODE_SEL: s_d.rdata = s_q.mode;
            IDX_CNT0_LO: s_d.rdata = s_q.lo0;
            IDX_CNT1_LO: s_d.rdata = s_q.lo1;
            IDX_CNT0_HI: s_d.rdata = s_q.hi0;
            IDX_CNT1_HI: s_d.rdata = s_q.hi1;
            IDX_THIRD_CTRL: s_d.rdata = s_q.ctrl3;
            IDX_THIRD_MODE: s_d.rdata = {6'h00, s_q.mode3};
            IDX_RELOAD_LO: s_d.rdata = s_q.rl_lo;
            IDX_RELOAD_HI: s_d.rdata = s_q.rl_hi;
            IDX_THIRD_LO: s_d.rdata = s_q.lo3;
            IDX_THIRD_HI: s_d.rdata = s_q.hi3;
            default: s_d.rdata = RST_BYTE;
         endcase
         if (!reg_mapped(paddr)) begin
            s_d.rdata = RST_BYTE;
         end
      end
   end

   // ************************************************************
   // State register and outputs
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.pin_oe_n <= 1'b1;
         s_q.mode3 <= RST_MODE3;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = {24'h000000, s_q.rdata};
   assign pready = s_q.ready;
   assign pslverr = s_q.slverr;
   assign timer_zero_irq = s_q.flags[ZERO_OVF];
   assign timer_one_irq = s_q.flags[ONE_OVF];
   assign ext_irq_zero_req = s_q.flags[EXT0_FLAG];
   assign ext_irq_one_req = s_q.flags[EXT1_FLAG];
   assign third_timer_irq = s_q.ctrl3[THIRD_OVF];
   assign third_timer_ovf_pulse = s_q.ovf_pulse;
   assign third_timer_count_pin_out = s_q.clk_out; // R19
   assign third_timer_count_pin_oe_n = s_q.pin_oe_n;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence tick_gap;
      !s_q.tick [*5] ##1 s_q.tick;
   endsequence

   chk_tick_period: assert property (s_q.tick |=> tick_gap) // R22
      else $error("peripheral tick not every six clocks");
   chk_zero_ovf_flag: assert property (zero_ovf |=> s_q.flags[ZERO_OVF]) // R2
      else $error("timer zero overflow flag not set");
   chk_one_ovf_flag: assert property (one_set |=> s_q.flags[ONE_OVF]) // R1
      else $error("timer one overflow flag not set");
   chk_zero_stopped: assert property ( // R3
      (!s_q.flags[ZERO_RUN] && !wr_any) |=> $stable(s_q.lo0))
      else $error("timer zero counted while stopped");
   chk_gated_hold: assert property ( // R6
      (s_q.mode[ZERO_GATING] && !ext0_hi && !wr_any) |=> $stable(s_q.lo0))
      else $error("gated timer zero counted with pin low");
   chk_reload_byte: assert property ( // R9
      (s_q.mode[ZERO_MODE +: 2] == MODE_RELOAD8 && zero_ovf && !wr_any)
      |=> (s_q.lo0 == $past(s_q.hi0)))
      else $error("low byte not reloaded from high byte");
   chk_one_halted: assert property ( // R10
      (s_q.mode[ONE_MODE +: 2] == MODE_SPLIT && !wr_any)
      |=> ($stable(s_q.lo1) && $stable(s_q.hi1)))
      else $error("halted timer one changed count");
   chk_up_reload: assert property ( // R14
      (third_hit && third_up && !wr_any) |=> (third_cnt == $past(third_rl)))
      else $error("up overflow did not load reload pair");
   chk_down_reload: assert property ( // R15
      (third_hit && !third_up && !wr_any) |=> (third_cnt == CNT_FULL))
      else $error("down underflow did not load all ones");
   chk_extf_toggle: assert property ( // R16
      (third_hit && third_updown && !wr_any)
      |=> (s_q.ctrl3[THIRD_EXTF] != $past(s_q.ctrl3[THIRD_EXTF])))
      else $error("external flag did not toggle on wrap");
   chk_clkout_quiet: assert property ( // R17
      (third_hit && s_q.mode3[CLK_OE] && !wr_any)
      |=> (s_q.clk_out != $past(s_q.clk_out)) &&
          $stable(s_q.ctrl3[THIRD_OVF]))
      else $error("clock-out wrap wrong or raised flag");
   chk_ext_level: assert property ( // R5
      (!s_q.flags[EXT0_TYPE] && !wr_any)
      |=> (s_q.flags[EXT0_FLAG] == !$past(ext0_hi)))
      else $error("level mode flag does not follow pin");
endmodule

// File: timer_block_tb.sv
// Self-checking testbench for the timer/counter block
`timescale 1ns/1ps
module timer_block_tb;
   import tmr_pkg::*;
   // ***************
   // Signals
   // ***************
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic cnt0_pin = 1'b1, cnt1_pin = 1'b1;
   logic irq0_pin_n = 1'b1, irq1_pin_n = 1'b1;
   logic dir_pin = 1'b1, third_in = 1'b1;
   logic third_out, third_oe_n;
   logic ack0 = 1'b0, ack1 = 1'b0, eack0 = 1'b0, eack1 = 1'b0;
   logic tz_irq, to_irq, ez_req, eo_req, th_irq, th_pulse;
   int error_cnt = 0;
   int comparisons = 0;
   logic [7:0] rd;
   logic err;
   // Half period of 10 ns gives 50 MHz
   always #10 pclk = ~pclk;
   timer_block u_timer_block (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_zero_count_pin(cnt0_pin),
      .timer_one_count_pin(cnt1_pin), .ext_irq_zero_pin_n(irq0_pin_n),
      .ext_irq_one_pin_n(irq1_pin_n), .direction_trigger_pin(dir_pin),
      .third_timer_count_pin_in(third_in),
      .third_timer_count_pin_out(third_out),
      .third_timer_count_pin_oe_n(third_oe_n),
      .timer_zero_irq_ack(ack0), .timer_one_irq_ack(ack1),
      .ext_irq_zero_ack(eack0), .ext_irq_one_ack(eack1),
      .timer_zero_irq(tz_irq), .timer_one_irq(to_irq),
      .ext_irq_zero_req(ez_req), .ext_irq_one_req(eo_req),
      .third_timer_irq(th_irq), .third_timer_ovf_pulse(th_pulse));
   // ***************
   // Compare, bus and wait helpers
   // ***************
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] idx,
                      input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h00_0000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      // Values read here are those standing before this edge
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk8(rd, exp);
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: sig = tz_irq;
         1: sig = to_irq;
         2: sig = ez_req;
         3: sig = eo_req;
         4: sig = th_irq;
         default: sig = third_out;
      endcase
   endfunction
   // Bounded wait for a level, then judged
   task automatic wait_sig(input int s, input logic lvl);
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (sig(s) !== lvl && n < 60);
      chk1(sig(s), lvl);
   endtask
   // One-cycle acknowledge: 0 timer zero, 1 timer one, 2 ext one, 3 ext zero
   task automatic pulse(input int k);
      @(posedge pclk);
      {eack0, eack1, ack1, ack0} <= 4'h1 << k;
      @(posedge pclk);
      {eack0, eack1, ack1, ack0} <= 4'h0;
   endtask
   // ***************
   // Scenarios
   // ***************
   task automatic t_reset_and_map();
      chk1(third_oe_n, 1'b1);
      rchk(IDX_CNT0_LO, 8'h00);
      rchk(IDX_CNT0_HI, 8'h00);
      apb(1'b0, 8'h00, 8'h00);
      chk1(err, 1'b1);
      chk8(rd, 8'h00);
   endtask
   task automatic t_mode16_overflow();
      wr(IDX_MODE_SEL, 8'h01);
      wr(IDX_CNT0_LO, 8'hff);
      wr(IDX_CNT0_HI, 8'hff);
      wr(IDX_RUN_FLAGS, 8'h10);
      wait_sig(0, 1'b1);
      rchk(IDX_CNT0_HI, 8'h00);
      pulse(0);
      wait_sig(0, 1'b0);
      wr(IDX_RUN_FLAGS, 8'h00);
   endtask
   task automatic t_mode13_prescale();
      wr(IDX_MODE_SEL, 8'h00);
      wr(IDX_CNT0_LO, 8'h1f);
      wr(IDX_CNT0_HI, 8'h00);
      wr(IDX_RUN_FLAGS, 8'h10);
      repeat (8) @(posedge pclk);
      wr(IDX_RUN_FLAGS, 8'h00);
      rchk(IDX_CNT0_HI, 8'h01);
   endtask
   task automatic t_reload8();
      wr(IDX_MODE_SEL, 8'h22);
      wr(IDX_CNT1_HI, 8'hf0);
      wr(IDX_CNT1_LO, 8'hff);
      wr(IDX_CNT0_HI, 8'h3c);
      wr(IDX_CNT0_LO, 8'hff);
      wr(IDX_RUN_FLAGS, 8'h50);
      wait_sig(1, 1'b1);
      chk1(tz_irq, 1'b1);
      // Stop both before the next tick; keep only timer one's flag
      wr(IDX_RUN_FLAGS, 8'h80);
      rchk(IDX_CNT1_LO, 8'hf0);
      rchk(IDX_CNT1_HI, 8'hf0);
      rchk(IDX_CNT0_LO, 8'h3c);
      pulse(1);
      wait_sig(1, 1'b0);
   endtask
   task automatic t_halt_and_split();
      wr(IDX_CNT1_LO, 8'h5a);
      wr(IDX_MODE_SEL, 8'h33);
      wr(IDX_CNT0_HI, 8'hff);
      wr(IDX_CNT0_LO, 8'h00);
      wr(IDX_RUN_FLAGS, 8'h40);
      wait_sig(1, 1'b1);
      chk1(tz_irq, 1'b0);
      rchk(IDX_CNT1_LO, 8'h5a);
      rchk(IDX_CNT0_LO, 8'h00);
      wr(IDX_RUN_FLAGS, 8'h00);
      pulse(1);
   endtask
   task automatic t_gating_and_counter();
      // Gate held low: no counting although the run bit is set
      wr(IDX_MODE_SEL, 8'h09);
      wr(IDX_CNT0_LO, 8'h00);
      @(posedge pclk) irq0_pin_n <= 1'b0;
      wr(IDX_RUN_FLAGS, 8'h10);
      repeat (60) @(posedge pclk);
      rchk(IDX_CNT0_LO, 8'h00);
      @(posedge pclk) irq0_pin_n <= 1'b1;
      repeat (60) @(posedge pclk);
      wr(IDX_RUN_FLAGS, 8'h00);
      apb(1'b0, IDX_CNT0_LO, 8'h00);
      chk1(rd != 8'h00, 1'b1);
      // Counter mode: three falls, each level held 16 pclk, over two cycles of six
      wr(IDX_MODE_SEL, 8'h05);
      wr(IDX_CNT0_LO, 8'h00);
      wr(IDX_RUN_FLAGS, 8'h10);
      repeat (3) begin
         @(posedge pclk) cnt0_pin <= 1'b0;
         repeat (15) @(posedge pclk);
         @(posedge pclk) cnt0_pin <= 1'b1;
         repeat (15) @(posedge pclk);
      end
      wr(IDX_RUN_FLAGS, 8'h00);
      rchk(IDX_CNT0_LO, 8'h03);
   endtask
   task automatic t_ext_irq();
      wr(IDX_RUN_FLAGS, 8'h04);
      @(posedge pclk) irq1_pin_n <= 1'b0;
      wait_sig(3, 1'b1);
      @(posedge pclk) irq1_pin_n <= 1'b1;
      pulse(2);
      wait_sig(3, 1'b0);
      wr(IDX_RUN_FLAGS, 8'h00);
      @(posedge pclk) irq0_pin_n <= 1'b0;
      wait_sig(2, 1'b1);
      @(posedge pclk) irq0_pin_n <= 1'b1;
      wait_sig(2, 1'b0);
   endtask
   task automatic t_third_up_down();
      wr(IDX_RELOAD_LO, 8'hf0);
      wr(IDX_RELOAD_HI, 8'hff);
      wr(IDX_THIRD_LO, 8'hfe);
      wr(IDX_THIRD_HI, 8'hff);
      wr(IDX_THIRD_CTRL, 8'h04);
      wait_sig(4, 1'b1);
      chk1(th_pulse, 1'b1);
      rchk(IDX_THIRD_LO, 8'hf0);
      wr(IDX_THIRD_CTRL, 8'h00);
      wr(IDX_THIRD_MODE, 8'h01);
      @(posedge pclk) dir_pin <= 1'b0;
      wr(IDX_RELOAD_LO, 8'h34);
      wr(IDX_RELOAD_HI, 8'h12);
      wr(IDX_THIRD_LO, 8'h36);
      wr(IDX_THIRD_HI, 8'h12);
      wr(IDX_THIRD_CTRL, 8'h04);
      wait_sig(4, 1'b1);
      rchk(IDX_THIRD_HI, 8'hff);
      rchk(IDX_THIRD_CTRL, 8'hc4);
      wr(IDX_THIRD_CTRL, 8'h00);
   endtask
   task automatic t_clock_out();
      int hi_n, lo_n;
      hi_n = 0;
      lo_n = 0;
      wr(IDX_THIRD_MODE, 8'h02);
      wr(IDX_THIRD_CTRL, 8'h00);
      wr(IDX_RELOAD_LO, 8'hfe);
      wr(IDX_RELOAD_HI, 8'hff);
      wr(IDX_THIRD_LO, 8'hfe);
      wr(IDX_THIRD_HI, 8'hff);
      wr(IDX_THIRD_CTRL, 8'h04);
      chk1(third_oe_n, 1'b0);
      wait_sig(5, 1'b0);
      wait_sig(5, 1'b1);
      // Reload fffe gives a period of 4*2 pclk, half high half low
      while (third_out === 1'b1 && hi_n < 50) begin
         @(negedge pclk);
         hi_n++;
      end
      while (third_out === 1'b0 && lo_n < 50) begin
         @(negedge pclk);
         lo_n++;
      end
      chk8(8'(hi_n), 8'h04);
      chk8(8'(lo_n), 8'h04);
      chk1(th_irq, 1'b0);
      wr(IDX_THIRD_CTRL, 8'h00);
   endtask
   // ***************
   // Verdict, watchdog and main sequence
   // ***************
   task automatic print_verdict();
      $display("Compared %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Whole run needs some 600 cycles; 20000 leaves wide margin
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      t_reset_and_map();
      t_mode16_overflow();
      t_mode13_prescale();
      t_reload8();
      t_halt_and_split();
      t_gating_and_counter();
      t_ext_irq();
      t_third_up_down();
      t_clock_out();
      print_verdict();
   end
endmodule
